/* File: dbc_pkg.sv */
// constants, command codes and states for the four-bank ddr2 command issuer
// assumes the memory clock equals core_clk, one command slot per cycle
package dbc_pkg;
	localparam int CLK_PS = 5000;
	localparam int T_RCD_PS = 15000;
	localparam int T_RP_PS = 15000;
	localparam int T_RFC_PS = 105000;
	localparam int T_WR_PS = 15000;
	localparam int T_WTR_PS = 7500;
	localparam int MRD_CYC = 2;
	localparam int WTR_MIN_CYC = 2;
	// least times round up to whole cycles
	localparam int RCD_CYC = (T_RCD_PS + CLK_PS - 1) / CLK_PS;
	localparam int RP_CYC = (T_RP_PS + CLK_PS - 1) / CLK_PS;
	localparam int RFC_CYC = (T_RFC_PS + CLK_PS - 1) / CLK_PS;
	localparam int WR_CYC = (T_WR_PS + CLK_PS - 1) / CLK_PS;
	localparam int WTR_RAW = (T_WTR_PS + CLK_PS - 1) / CLK_PS;
	localparam int WTR_CYC = (WTR_RAW > WTR_MIN_CYC) ? WTR_RAW : WTR_MIN_CYC;
	localparam int AP_BIT = 10;
	localparam int BANKS = 4;
	localparam int CNT_W = 8;
	// {ras_n, cas_n, we_n} with chip select low
	localparam logic [2:0] PAT_NOP = 3'h7;
	localparam logic [2:0] PAT_REF = 3'h1;
	localparam logic [2:0] PAT_LMR = 3'h0;
	localparam logic [2:0] PAT_ACT = 3'h3;
	localparam logic [2:0] PAT_RD = 3'h5;
	localparam logic [2:0] PAT_WR = 3'h4;
	localparam logic [2:0] PAT_PRE = 3'h2;
	typedef enum logic [2:0] {
		CMD_NOP = 3'h0,
		CMD_ACT = 3'h1,
		CMD_RD = 3'h2,
		CMD_WR = 3'h3,
		CMD_PRE = 3'h4,
		CMD_PREA = 3'h5,
		CMD_REF = 3'h6,
		CMD_LMR = 3'h7
	} dbc_cmd_t;
	typedef enum logic [2:0] {
		ST_RESET = 3'h1,
		ST_WAKE = 3'h2,
		ST_RUN = 3'h4
	} dbc_state_t;
endpackage

/* File: dbc_ctrl.sv */
// host-side command issuer for a four-bank ddr2 device with per-bank legality
// assumes requests come from logic on core_clk; pins feed the device directly
`timescale 1ns/1ps
module dbc_ctrl #(
	parameter int CL = 4,
	parameter int BL = 4,
	parameter int ROW_W = 14
) (
	// clock, reset, freeze
	input wire logic core_clk,
	input wire logic reset,
	input wire logic clkEn,
	// request port
	input wire logic reqValid,
	input wire dbc_pkg::dbc_cmd_t reqCmd,
	input wire logic [1:0] reqBank,
	input wire logic [ROW_W-1:0] reqAddr,
	input wire logic reqAutoPre,
	output logic reqDone,
	output logic reqIllegal,
	output logic [3:0] bankOpen,
	// device command pins
	output logic ddrCke,
	output logic ddrCsN,
	output logic ddrRasN,
	output logic ddrCasN,
	output logic ddrWeN,
	output logic [1:0] ddrBa,
	output logic [ROW_W-1:0] ddrAddr
);
	localparam int BURST = BL / 2;
	localparam int RD_WR_CYC = BURST + 2;
	localparam int WR_RD_CYC = (CL - 1) + BURST + dbc_pkg::WTR_CYC;
	localparam int WR_PRE_CYC = (CL - 1) + BURST + dbc_pkg::WR_CYC;
	localparam int RDAP_CYC = BURST + dbc_pkg::RP_CYC;
	localparam int WRAP_CYC = WR_PRE_CYC + dbc_pkg::RP_CYC;
	localparam int W = dbc_pkg::CNT_W;
	// counters hold cycles still to wait minus one, so zero means go now
	localparam logic [W-1:0] L_RCD = W'(dbc_pkg::RCD_CYC - 1);
	localparam logic [W-1:0] L_RP = W'(dbc_pkg::RP_CYC - 1);
	localparam logic [W-1:0] L_RFC = W'(dbc_pkg::RFC_CYC - 1);
	localparam logic [W-1:0] L_MRD = W'(dbc_pkg::MRD_CYC - 1);
	localparam logic [W-1:0] L_BURST = W'(BURST - 1);
	localparam logic [W-1:0] L_RD_WR = W'(RD_WR_CYC - 1);
	localparam logic [W-1:0] L_WR_RD = W'(WR_RD_CYC - 1);
	localparam logic [W-1:0] L_WR_PRE = W'(WR_PRE_CYC - 1);
	localparam logic [W-1:0] L_RDAP = W'(RDAP_CYC - 1);
	localparam logic [W-1:0] L_WRAP = W'(WRAP_CYC - 1);
	localparam logic [W-1:0] ONE = W'(1);

	// counters are CNT_W bits wide and a10 must exist, so refuse what they cannot hold
	if ((BL != 4 && BL != 8) || CL < 3 || CL > 7 || ROW_W < 11 || WRAP_CYC > 250
		|| dbc_pkg::RFC_CYC > 250)
	begin : g_bad_param
		$error("dbc_ctrl: burst length, cas latency, width or timing count not supported");
	end

	dbc_pkg::dbc_state_t stateQ;
	logic openQ [dbc_pkg::BANKS];
	logic [W-1:0] lockQ [dbc_pkg::BANKS];
	logic [W-1:0] preWaitQ [dbc_pkg::BANKS];
	logic [dbc_pkg::BANKS-1:0] bankFree;
	logic [dbc_pkg::BANKS-1:0] bankPreOk;
	logic [W-1:0] lockAllQ;
	logic [W-1:0] gapRdQ;
	logic [W-1:0] gapWrQ;
	logic reqDoneQ;
	logic reqIllegalQ;
	logic legal;
	logic illegal;
	logic go;
	logic bad;
	logic allClosed;
	logic selOpen;
	logic selFree;
	logic selPreOk;

	// power-on: raise cke, then wait one more edge so two samples are high
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			stateQ <= dbc_pkg::ST_RESET;
			ddrCke <= 1'b0;
		end
		else if (clkEn)
		begin
			unique case (stateQ)
				dbc_pkg::ST_RESET:
				begin
					stateQ <= dbc_pkg::ST_WAKE;
					ddrCke <= 1'b1;
				end
				dbc_pkg::ST_WAKE:
					stateQ <= dbc_pkg::ST_RUN;
				dbc_pkg::ST_RUN:
					stateQ <= dbc_pkg::ST_RUN;
				default:
					stateQ <= dbc_pkg::ST_RESET;
			endcase
		end
	end

	// per-bank row flag and lockout timers
	genvar b;
	generate
		for (b = 0; b < dbc_pkg::BANKS; b++)
		begin : g_bank
			logic hit;
			assign hit = go && (reqBank == 2'(b));
			assign bankFree[b] = (lockQ[b] == '0);
			assign bankPreOk[b] = (lockQ[b] == '0) && (preWaitQ[b] == '0);
			assign bankOpen[b] = openQ[b];
			always_ff @(posedge core_clk)
			begin
				if (reset)
				begin
					openQ[b] <= 1'b0;
					lockQ[b] <= '0;
					preWaitQ[b] <= '0;
				end
				else if (clkEn)
				begin
					if (go && reqCmd == dbc_pkg::CMD_PREA)
						openQ[b] <= 1'b0;
					else if (hit && reqCmd == dbc_pkg::CMD_ACT)
					begin
						openQ[b] <= 1'b1;
						lockQ[b] <= L_RCD;
					end
					else if (hit && reqCmd == dbc_pkg::CMD_PRE)
					begin
						openQ[b] <= 1'b0;
						lockQ[b] <= L_RP;
					end
					else if (hit && reqCmd == dbc_pkg::CMD_RD && reqAutoPre)
					begin
						// internal precharge starts when the burst has left
						openQ[b] <= 1'b0;
						lockQ[b] <= L_RDAP;
					end
					else if (hit && reqCmd == dbc_pkg::CMD_WR && reqAutoPre)
					begin
						openQ[b] <= 1'b0;
						lockQ[b] <= L_WRAP;
					end
					else if (hit && reqCmd == dbc_pkg::CMD_RD)
						preWaitQ[b] <= L_BURST;
					else if (hit && reqCmd == dbc_pkg::CMD_WR)
						preWaitQ[b] <= L_WR_PRE;
					else
					begin
						if (lockQ[b] != '0)
							lockQ[b] <= lockQ[b] - ONE;
						if (preWaitQ[b] != '0)
							preWaitQ[b] <= preWaitQ[b] - ONE;
					end
				end
			end
		end
	endgenerate

	// legality of the waiting request against bank and device state
	always_comb
	begin
		allClosed = !(openQ[0] || openQ[1] || openQ[2] || openQ[3]);
		selOpen = openQ[reqBank];
		selFree = bankFree[reqBank];
		selPreOk = bankPreOk[reqBank];
		legal = 1'b0;
		illegal = 1'b0;
		unique case (reqCmd)
			dbc_pkg::CMD_NOP:
				legal = 1'b1;
			dbc_pkg::CMD_ACT:
			begin
				illegal = selOpen;
				legal = selFree;
			end
			dbc_pkg::CMD_RD:
			begin
				illegal = !selOpen;
				legal = selFree && (gapRdQ == '0);
			end
			dbc_pkg::CMD_WR:
			begin
				illegal = !selOpen;
				legal = selFree && (gapWrQ == '0);
			end
			dbc_pkg::CMD_PRE:
				legal = selPreOk;
			dbc_pkg::CMD_PREA:
				legal = &bankPreOk;
			dbc_pkg::CMD_REF, dbc_pkg::CMD_LMR:
			begin
				illegal = !allClosed;
				legal = (&bankFree) && gapRdQ == '0 && gapWrQ == '0;
			end
		endcase
		go = clkEn && stateQ == dbc_pkg::ST_RUN && reqValid && !reqDoneQ && lockAllQ == '0
			&& legal && !illegal;
		bad = clkEn && stateQ == dbc_pkg::ST_RUN && reqValid && !reqDoneQ && illegal;
	end

	// device-wide lockouts and bus turnaround spacing
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			lockAllQ <= '0;
			gapRdQ <= '0;
			gapWrQ <= '0;
		end
		else if (clkEn)
		begin
			if (go && reqCmd == dbc_pkg::CMD_REF)
				lockAllQ <= L_RFC;
			else if (go && reqCmd == dbc_pkg::CMD_PREA)
				lockAllQ <= L_RP;
			else if (go && reqCmd == dbc_pkg::CMD_LMR)
				lockAllQ <= L_MRD;
			else if (lockAllQ != '0)
				lockAllQ <= lockAllQ - ONE;
			// read and write data share one bus; these gaps keep them apart
			if (go && reqCmd == dbc_pkg::CMD_RD)
			begin
				gapRdQ <= L_BURST;
				gapWrQ <= L_RD_WR;
			end
			else if (go && reqCmd == dbc_pkg::CMD_WR)
			begin
				gapRdQ <= L_WR_RD;
				gapWrQ <= L_BURST;
			end
			else
			begin
				if (gapRdQ != '0)
					gapRdQ <= gapRdQ - ONE;
				if (gapWrQ != '0)
					gapWrQ <= gapWrQ - ONE;
			end
		end
	end

	// command pins: deselect in every slot without an issued command
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			ddrCsN <= 1'b1;
			{ddrRasN, ddrCasN, ddrWeN} <= dbc_pkg::PAT_NOP;
			ddrBa <= '0;
			ddrAddr <= '0;
		end
		else if (clkEn)
		begin
			ddrCsN <= !(go && reqCmd != dbc_pkg::CMD_NOP);
			ddrBa <= reqBank;
			ddrAddr <= reqAddr;
			{ddrRasN, ddrCasN, ddrWeN} <= dbc_pkg::PAT_NOP;
			if (go)
			begin
				unique case (reqCmd)
					dbc_pkg::CMD_NOP:
						{ddrRasN, ddrCasN, ddrWeN} <= dbc_pkg::PAT_NOP;
					dbc_pkg::CMD_ACT:
						{ddrRasN, ddrCasN, ddrWeN} <= dbc_pkg::PAT_ACT;
					dbc_pkg::CMD_RD:
					begin
						{ddrRasN, ddrCasN, ddrWeN} <= dbc_pkg::PAT_RD;
						ddrAddr[dbc_pkg::AP_BIT] <= reqAutoPre;
					end
					dbc_pkg::CMD_WR:
					begin
						{ddrRasN, ddrCasN, ddrWeN} <= dbc_pkg::PAT_WR;
						ddrAddr[dbc_pkg::AP_BIT] <= reqAutoPre;
					end
					dbc_pkg::CMD_PRE:
					begin
						{ddrRasN, ddrCasN, ddrWeN} <= dbc_pkg::PAT_PRE;
						ddrAddr[dbc_pkg::AP_BIT] <= 1'b0;
					end
					dbc_pkg::CMD_PREA:
					begin
						{ddrRasN, ddrCasN, ddrWeN} <= dbc_pkg::PAT_PRE;
						ddrAddr[dbc_pkg::AP_BIT] <= 1'b1;
					end
					dbc_pkg::CMD_REF:
						{ddrRasN, ddrCasN, ddrWeN} <= dbc_pkg::PAT_REF;
					dbc_pkg::CMD_LMR:
						{ddrRasN, ddrCasN, ddrWeN} <= dbc_pkg::PAT_LMR;
				endcase
			end
		end
	end

	// request answers; an illegal request is dropped and never reaches the pins
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			reqDoneQ <= 1'b0;
			reqIllegalQ <= 1'b0;
		end
		else if (clkEn)
		begin
			reqDoneQ <= go || bad;
			reqIllegalQ <= bad;
		end
	end
	assign reqDone = reqDoneQ;
	assign reqIllegal = reqIllegalQ;

	// helper counters that measure pin spacing for the checks below
	logic [2:0] pinCmd;
	logic pinLive;
	logic [W-1:0] sinceRefQ;
	logic [W-1:0] sincePreaQ;
	logic [W-1:0] sinceLmrQ;
	logic [W-1:0] sinceActQ;
	logic [W-1:0] sinceRdQ;
	logic [W-1:0] sinceWrQ;
	logic [1:0] lastActBaQ;
	logic ckePrevQ;
	assign pinCmd = {ddrRasN, ddrCasN, ddrWeN};
	assign pinLive = !ddrCsN && pinCmd != dbc_pkg::PAT_NOP;

	function automatic logic [W-1:0] bump(input logic [W-1:0] v, input logic hitNow);
		logic [W-1:0] r;
		r = (v == '1) ? v : v + ONE;
		if (hitNow)
			r = ONE;
		return r;
	endfunction

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			sinceRefQ <= '1;
			sincePreaQ <= '1;
			sinceLmrQ <= '1;
			sinceActQ <= '1;
			sinceRdQ <= '1;
			sinceWrQ <= '1;
			lastActBaQ <= '0;
			ckePrevQ <= 1'b0;
		end
		else if (clkEn)
		begin
			ckePrevQ <= ddrCke;
			sinceRefQ <= bump(sinceRefQ, pinLive && pinCmd == dbc_pkg::PAT_REF);
			sincePreaQ <= bump(sincePreaQ, pinLive && pinCmd == dbc_pkg::PAT_PRE
				&& ddrAddr[dbc_pkg::AP_BIT]);
			sinceLmrQ <= bump(sinceLmrQ, pinLive && pinCmd == dbc_pkg::PAT_LMR);
			sinceActQ <= bump(sinceActQ, pinLive && pinCmd == dbc_pkg::PAT_ACT);
			sinceRdQ <= bump(sinceRdQ, pinLive && pinCmd == dbc_pkg::PAT_RD);
			sinceWrQ <= bump(sinceWrQ, pinLive && pinCmd == dbc_pkg::PAT_WR);
			if (pinLive && pinCmd == dbc_pkg::PAT_ACT)
				lastActBaQ <= ddrBa;
		end
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (reset || !clkEn);

	property p_cke_twice;
		pinLive |-> ddrCke && ckePrevQ;
	endproperty
	a_cke_twice: assert property (p_cke_twice) else $error("command with cke not high twice");

	property p_illegal_quiet;
		reqIllegal |-> ddrCsN;
	endproperty
	a_illegal_quiet: assert property (p_illegal_quiet) else $error("illegal request reached pins");

	property p_act_pattern;
		go && reqCmd == dbc_pkg::CMD_ACT |=> !ddrCsN && pinCmd == dbc_pkg::PAT_ACT
			&& ddrBa == $past(reqBank) && reqDone ##1 !ddrCsN == 1'b0 || pinLive;
	endproperty
	a_act_pattern: assert property (p_act_pattern) else $error("activate pattern wrong");

	property p_ref_quiet;
		pinLive |-> sinceRefQ >= W'(dbc_pkg::RFC_CYC);
	endproperty
	a_ref_quiet: assert property (p_ref_quiet) else $error("command inside refresh interval");

	property p_prea_quiet;
		pinLive |-> sincePreaQ >= W'(dbc_pkg::RP_CYC);
	endproperty
	a_prea_quiet: assert property (p_prea_quiet) else $error("command inside precharge all");

	property p_lmr_quiet;
		pinLive |-> sinceLmrQ >= W'(dbc_pkg::MRD_CYC);
	endproperty
	a_lmr_quiet: assert property (p_lmr_quiet) else $error("command inside mode load wait");

	property p_act_lock;
		pinLive && ddrBa == lastActBaQ && pinCmd != dbc_pkg::PAT_REF
			&& pinCmd != dbc_pkg::PAT_LMR |-> sinceActQ >= W'(dbc_pkg::RCD_CYC);
	endproperty
	a_act_lock: assert property (p_act_lock) else $error("same bank command inside trcd");

	property p_ref_idle;
		pinLive && pinCmd == dbc_pkg::PAT_REF |-> bankOpen == 4'h0;
	endproperty
	a_ref_idle: assert property (p_ref_idle) else $error("refresh with an open bank");

	property p_rd_to_wr;
		pinLive && pinCmd == dbc_pkg::PAT_WR |-> sinceRdQ >= W'(RD_WR_CYC);
	endproperty
	a_rd_to_wr: assert property (p_rd_to_wr) else $error("write too soon after read");

	property p_wr_to_rd;
		pinLive && pinCmd == dbc_pkg::PAT_RD |-> sinceWrQ >= W'(WR_RD_CYC);
	endproperty
	a_wr_to_rd: assert property (p_wr_to_rd) else $error("read too soon after write");

	property p_rdap_closes;
		go && reqCmd == dbc_pkg::CMD_RD && reqAutoPre |=> bankOpen[$past(reqBank)] == 1'b0;
	endproperty
	a_rdap_closes: assert property (p_rdap_closes) else $error("auto precharge left row open");

	c_act_rd: cover property (pinLive && pinCmd == dbc_pkg::PAT_ACT ##[1:10]
		pinLive && pinCmd == dbc_pkg::PAT_RD);
	c_wr_ap: cover property (pinLive && pinCmd == dbc_pkg::PAT_WR && ddrAddr[dbc_pkg::AP_BIT]);
	c_refresh: cover property (pinLive && pinCmd == dbc_pkg::PAT_REF);
	c_illegal: cover property (reqIllegal);
endmodule // dbc_ctrl

/* File: dbc_ddr_model.sv */
// behavioural four-bank ddr2 device that flags every command it may not take
// assumes it samples the controller pins on core_clk; counts faults on violCnt
`timescale 1ns/1ps
module dbc_ddr_model #(
	parameter int CL = 4,
	parameter int BL = 4,
	parameter int ROW_W = 14
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// command pins
	input wire logic cke,
	input wire logic csN,
	input wire logic rasN,
	input wire logic casN,
	input wire logic weN,
	input wire logic [1:0] ba,
	input wire logic [ROW_W-1:0] addr,
	// fault count
	output int violCnt
);
	// timers kept as absolute cycle stamps, so idle banks cost nothing
	int readyAt[4];
	int preAt[4];
	logic [3:0] rowOpen;
	int cyc;
	int allAt;
	int rdAt;
	int wrAt;
	logic ckePrev;
	int b;

	function automatic int mx(input int x, input int y);
		return (x > y) ? x : y;
	endfunction

	task automatic viol(input string what);
		violCnt++;
		$display("[ERR] %s expected legal seen illegal, cycle %0d", what, cyc);
	endtask

	function automatic logic allIdle();
		allIdle = (rowOpen == 4'h0);
		for (int k = 0; k < 4; k++)
			if (cyc < readyAt[k])
				allIdle = 0;
	endfunction

	always @(posedge core_clk)
	begin
		if (reset)
		begin
			cyc = 0;
			rowOpen = 4'h0;
			allAt = 0;
			rdAt = 0;
			wrAt = 0;
			ckePrev = 0;
			readyAt = '{default: 0};
			preAt = '{default: 0};
		end
		else
		begin
			cyc++;
			b = ba;
			// deselect and nop leave all timers running
			if (!csN && {rasN, casN, weN} != dbc_pkg::PAT_NOP)
			begin
				if (!(cke && ckePrev))
					viol("cke");
				if (cyc < allAt)
					viol("global lock");
				case ({rasN, casN, weN})
					dbc_pkg::PAT_ACT:
					begin
						if (rowOpen[b] || cyc < readyAt[b])
							viol("activate");
						rowOpen[b] = 1;
						readyAt[b] = cyc + dbc_pkg::RCD_CYC;
					end
					dbc_pkg::PAT_RD:
					begin
						if (!rowOpen[b] || cyc < readyAt[b] || cyc < rdAt)
							viol("read");
						rdAt = cyc + BL / 2;
						wrAt = mx(wrAt, cyc + BL / 2 + 2);
						preAt[b] = mx(preAt[b], cyc + BL / 2);
						if (addr[dbc_pkg::AP_BIT])
						begin
							rowOpen[b] = 0;
							readyAt[b] = preAt[b] + dbc_pkg::RP_CYC;
						end
					end
					dbc_pkg::PAT_WR:
					begin
						if (!rowOpen[b] || cyc < readyAt[b] || cyc < wrAt)
							viol("write");
						wrAt = mx(wrAt, cyc + BL / 2);
						rdAt = mx(rdAt, cyc + CL - 1 + BL / 2 + dbc_pkg::WTR_CYC);
						preAt[b] = cyc + CL - 1 + BL / 2 + dbc_pkg::WR_CYC;
						if (addr[dbc_pkg::AP_BIT])
						begin
							rowOpen[b] = 0;
							readyAt[b] = preAt[b] + dbc_pkg::RP_CYC;
						end
					end
					dbc_pkg::PAT_PRE:
					begin
						for (int k = 0; k < 4; k++)
							if (addr[dbc_pkg::AP_BIT] || k == b)
							begin
								if (cyc < readyAt[k] || cyc < preAt[k])
									viol("precharge");
								rowOpen[k] = 0;
								readyAt[k] = cyc + dbc_pkg::RP_CYC;
							end
						if (addr[dbc_pkg::AP_BIT])
							allAt = cyc + dbc_pkg::RP_CYC;
					end
					dbc_pkg::PAT_REF, dbc_pkg::PAT_LMR:
					begin
						if (!allIdle())
							viol("all-bank command");
						allAt = cyc + (weN ? dbc_pkg::RFC_CYC : dbc_pkg::MRD_CYC);
					end
					default:
						viol("reserved code");
				endcase
			end
			ckePrev = cke;
		end
	end
endmodule // dbc_ddr_model

/* File: test_ddr2_bank_command_legality.sv */
// self-checking bench: request port driven by tasks, device model on the pins
// assumes default design parameters and a 200 MHz core_clk
`timescale 1ns/1ps
module test_ddr2_bank_command_legality;
	logic core_clk = 0;
	logic reset = 1;
	logic clkEn = 1;
	logic reqValid = 0;
	dbc_pkg::dbc_cmd_t reqCmd = dbc_pkg::CMD_NOP;
	logic [1:0] reqBank = 2'h0;
	logic [13:0] reqAddr = 14'h0123;
	logic reqAutoPre = 0;
	logic reqDone;
	logic reqIllegal;
	logic [3:0] bankOpen;
	logic ddrCke;
	logic ddrCsN;
	logic ddrRasN;
	logic ddrCasN;
	logic ddrWeN;
	logic [1:0] ddrBa;
	logic [13:0] ddrAddr;
	int violCnt;
	int n_mismatch = 0;
	int num_checks = 0;
	logic [2:0] patOf[8] = '{dbc_pkg::PAT_NOP, dbc_pkg::PAT_ACT, dbc_pkg::PAT_RD, dbc_pkg::PAT_WR,
		dbc_pkg::PAT_PRE, dbc_pkg::PAT_PRE, dbc_pkg::PAT_REF, dbc_pkg::PAT_LMR};

	always #2.5 core_clk = ~core_clk;

	dbc_ctrl dbc_ctrl_i (.core_clk(core_clk), .reset(reset), .clkEn(clkEn),
		.reqValid(reqValid), .reqCmd(reqCmd), .reqBank(reqBank), .reqAddr(reqAddr),
		.reqAutoPre(reqAutoPre), .reqDone(reqDone), .reqIllegal(reqIllegal),
		.bankOpen(bankOpen), .ddrCke(ddrCke), .ddrCsN(ddrCsN), .ddrRasN(ddrRasN),
		.ddrCasN(ddrCasN), .ddrWeN(ddrWeN), .ddrBa(ddrBa), .ddrAddr(ddrAddr));

	dbc_ddr_model dbc_ddr_model_i (.core_clk(core_clk), .reset(reset), .cke(ddrCke),
		.csN(ddrCsN), .rasN(ddrRasN), .casN(ddrCasN), .weN(ddrWeN), .ba(ddrBa),
		.addr(ddrAddr), .violCnt(violCnt));

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
		num_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// called at a falling edge; leaves the request up so the next may follow at once
	task automatic issue(input dbc_pkg::dbc_cmd_t c, input logic [1:0] b, input logic ap,
		input logic bad);
		int n;
		reqValid = 1;
		reqCmd = c;
		reqBank = b;
		reqAutoPre = ap;
		n = 0;
		do
		begin
			@(negedge core_clk);
			n++;
		end
		while (reqDone !== 1'b1 && n < 200);
		if (n >= 200)
		begin
			n_mismatch++;
			$display("[ERR] reqDone expected 1 seen timeout");
			report_and_stop;
		end
		check("reqIllegal", bad, reqIllegal);
		check("csN", bad || c == dbc_pkg::CMD_NOP, ddrCsN);
		if (!bad && c != dbc_pkg::CMD_NOP)
		begin
			check("pattern", patOf[c], {ddrRasN, ddrCasN, ddrWeN});
			check("bank", b, ddrBa);
			if (c == dbc_pkg::CMD_ACT || c == dbc_pkg::CMD_LMR)
				check("addr", reqAddr, ddrAddr);
			if (c == dbc_pkg::CMD_RD || c == dbc_pkg::CMD_WR)
				check("a10", ap, ddrAddr[10]);
			if (c == dbc_pkg::CMD_PRE || c == dbc_pkg::CMD_PREA)
				check("a10", c == dbc_pkg::CMD_PREA, ddrAddr[10]);
		end
	endtask

	task automatic idle(input int n);
		reqValid = 0;
		repeat (n) @(negedge core_clk);
	endtask

	task automatic scen_open_close;
		issue(dbc_pkg::CMD_ACT, 2'h0, 0, 0);
		issue(dbc_pkg::CMD_RD, 2'h0, 0, 0);
		issue(dbc_pkg::CMD_WR, 2'h0, 0, 0);
		issue(dbc_pkg::CMD_ACT, 2'h3, 0, 0);
		issue(dbc_pkg::CMD_RD, 2'h3, 0, 0);
		issue(dbc_pkg::CMD_PRE, 2'h0, 0, 0);
		issue(dbc_pkg::CMD_ACT, 2'h0, 0, 0);
		idle(10);
		check("bankOpen", 4'h9, bankOpen);
	endtask

	task automatic scen_illegal;
		issue(dbc_pkg::CMD_RD, 2'h1, 0, 1);
		issue(dbc_pkg::CMD_WR, 2'h2, 1, 1);
		issue(dbc_pkg::CMD_ACT, 2'h0, 0, 1);
		issue(dbc_pkg::CMD_REF, 2'h0, 0, 1);
		issue(dbc_pkg::CMD_LMR, 2'h1, 0, 1);
		issue(dbc_pkg::CMD_NOP, 2'h0, 0, 0);
		idle(2);
		check("bankOpen", 4'h9, bankOpen);
	endtask

	task automatic scen_autopre;
		issue(dbc_pkg::CMD_ACT, 2'h1, 0, 0);
		issue(dbc_pkg::CMD_RD, 2'h1, 1, 0);
		issue(dbc_pkg::CMD_WR, 2'h0, 0, 0);
		issue(dbc_pkg::CMD_WR, 2'h3, 1, 0);
		issue(dbc_pkg::CMD_RD, 2'h0, 0, 0);
		issue(dbc_pkg::CMD_ACT, 2'h3, 0, 0);
		issue(dbc_pkg::CMD_ACT, 2'h1, 0, 0);
		issue(dbc_pkg::CMD_PRE, 2'h1, 0, 0);
		idle(40);
		check("bankOpen", 4'h9, bankOpen);
	endtask

	task automatic scen_global;
		issue(dbc_pkg::CMD_PREA, 2'h0, 0, 0);
		issue(dbc_pkg::CMD_REF, 2'h0, 0, 0);
		issue(dbc_pkg::CMD_LMR, 2'h2, 0, 0);
		issue(dbc_pkg::CMD_ACT, 2'h2, 0, 0);
		idle(3);
		check("bankOpen", 4'h4, bankOpen);
	endtask

	task automatic scen_freeze;
		clkEn = 0;
		reqValid = 1;
		reqCmd = dbc_pkg::CMD_PRE;
		reqBank = 2'h2;
		repeat (4)
		begin
			@(negedge core_clk);
			check("frozen reqDone", 0, reqDone);
		end
		clkEn = 1;
		issue(dbc_pkg::CMD_PRE, 2'h2, 0, 0);
		idle(4);
		check("bankOpen", 4'h0, bankOpen);
	endtask

	// reset in mid-run: state clears, the next request waits for cke twice high
	task automatic scen_reset;
		issue(dbc_pkg::CMD_ACT, 2'h1, 0, 0);
		reset = 1;
		reqValid = 0;
		repeat (2) @(negedge core_clk);
		check("bankOpen", 4'h0, bankOpen);
		check("cke", 0, ddrCke);
		check("csN", 1, ddrCsN);
		check("reqDone", 0, reqDone);
		reset = 0;
		issue(dbc_pkg::CMD_ACT, 2'h1, 0, 0);
		check("bankOpen", 4'h2, bankOpen);
		idle(2);
	endtask

	initial
	begin
		repeat (4) @(negedge core_clk);
		check("cke", 0, ddrCke);
		check("csN", 1, ddrCsN);
		reset = 0;
		@(negedge core_clk);
		check("cke", 1, ddrCke);
		scen_open_close();
		scen_illegal();
		scen_autopre();
		scen_global();
		scen_freeze();
		scen_reset();
		check("model faults", 0, violCnt);
		report_and_stop();
	end
endmodule // test_ddr2_bank_command_legality
